// ### afepg_pkg.sv
// Package with register map, field layout and config carrier of the bank
package afepg_pkg;
  // Register word width and address width
  localparam int AFEPG_DW = 24;
  localparam int AFEPG_AW = 5;
  // Register offsets
  localparam logic [4:0] AFEPG_OFS_PHASE45 = 5'h09;
  localparam logic [4:0] AFEPG_OFS_PHASE_LO = 5'h0a;
  localparam logic [4:0] AFEPG_OFS_GAIN = 5'h0b;
  localparam logic [4:0] AFEPG_OFS_STATUS = 5'h0c;
  // Address walk limits
  localparam logic [4:0] AFEPG_MAP_LAST = 5'h1f;
  localparam logic [4:0] AFEPG_WR_FIRST = 5'h09;
  localparam logic [4:0] AFEPG_TYPE_SPLIT = 5'h08;
  // Field positions
  localparam int AFEPG_DLY_W = 12;
  localparam int AFEPG_POS_PAIR23 = 12;
  localparam int AFEPG_POS_PAIR01 = 0;
  localparam int AFEPG_POS_PAIR45 = 0;
  localparam int AFEPG_GAIN_W = 3;
  localparam int AFEPG_POS_READ = 22;
  localparam int AFEPG_POS_WRITE = 21;
  localparam int AFEPG_POS_IDLE = 20;
  localparam int AFEPG_POS_COMBINE = 19;
  localparam int AFEPG_POS_CRCW = 18;
  localparam int AFEPG_POS_DATAW = 16;
  localparam int AFEPG_POS_COMMCRC = 15;
  localparam int AFEPG_POS_INTEN = 14;
  localparam int AFEPG_POS_FLAGS = 0;
  // Reset values
  localparam logic [1:0] AFEPG_RST_READ = 2'h2;
  localparam logic AFEPG_RST_WRITE = 1'b1;
  localparam logic [1:0] AFEPG_RST_DATAW = 2'h1;
  localparam logic [5:0] AFEPG_RST_FLAGS = 6'h3f;
  localparam logic [7:0] AFEPG_LOCK_KEY = 8'ha5;
  // Gain codes
  localparam logic [2:0] AFEPG_GAIN_MAX = 3'h5;
  // Read address walk modes
  typedef enum logic [1:0] {
    AFEPG_RD_SAME = 2'h0,
    AFEPG_RD_GROUP = 2'h1,
    AFEPG_RD_TYPE = 2'h2,
    AFEPG_RD_MAP = 2'h3
  } afepg_rd_e;
  // Decoded configuration handed to the datapath and serial framer
  typedef struct packed {
    logic [1:0] read_inc;
    logic write_inc;
    logic idle_drive;
    logic combine;
    logic crc32;
    logic [1:0] data_width;
    logic comm_crc;
    logic int_en;
  } afepg_cfg_s;
endpackage : afepg_pkg

// ### afepg_regs.sv
// Phase, gain and status/communication register bank with data-ready pin
// Operation
// - Phase register write restarts active channels
// - Pair45 delay field in phase45 bits 11-0
// - Pair23 delay field in bits 23-12
// - Pair01 delay field in bits 11-0
// - Three-bit gain per channel, reserved codes unity
// - Read increment selects read address walk
// - Write increment wraps within writable range
// - Idle pin driven high or floated
// - Combined or per-channel data-ready pulses
// - Checksum width bit selects 16/32 bits
// - Data width field formats output words
// - Communication checksum enable, zero after reset
// - Map checksum error holds pin low
// - Interrupt disabled means no pin alarm
// - Ready flags low when data new
// - Status read sets flags; data read not
// - Unimplemented bits read zero
// - Combined mode latches all outputs together
`timescale 1ns/1ps
module afepg_regs #(
  parameter int CHANNELS = 6
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic [afepg_pkg::AFEPG_AW-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [afepg_pkg::AFEPG_DW-1:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic i_chan_data_rd,
  input wire logic [CHANNELS-1:0] i_chan_active,
  input wire logic [CHANNELS-1:0] i_chan_ready,
  input wire logic i_map_crc_error,
  input wire logic [7:0] i_lock_key,
  output logic [afepg_pkg::AFEPG_DW-1:0] o_reg_rdata,
  output logic [afepg_pkg::AFEPG_AW-1:0] o_next_rd_addr,
  output logic [afepg_pkg::AFEPG_AW-1:0] o_next_wr_addr,
  output afepg_pkg::afepg_cfg_s o_cfg,
  output logic [CHANNELS*3-1:0] o_gain_shift,
  output logic [CHANNELS-1:0] o_chan_restart,
  output logic [CHANNELS-1:0] o_chan_start,
  output logic [CHANNELS-1:0] o_chan_latch,
  output logic o_ready_pin_out,
  output logic o_ready_pin_oe
);
  import afepg_pkg::*;

  localparam int PAIRS = CHANNELS / 2;

  logic rst_meta;
  logic rst_n;
  logic [AFEPG_DLY_W-1:0] delay_pair45;
  logic [AFEPG_DLY_W-1:0] delay_pair23;
  logic [AFEPG_DLY_W-1:0] delay_pair01;
  logic [CHANNELS*3-1:0] channel_gain_code;
  afepg_cfg_s cfg;
  logic [CHANNELS-1:0] channel_ready_flags;
  logic [CHANNELS-1:0] pending;
  logic dr_pulse;
  logic alarm_hold;
  logic restart_q;
  logic [CHANNELS-1:0] active_q;
  logic wr_phase;
  logic rd_status;
  logic [CHANNELS-1:0] covered;
  logic combined_fire;
  logic [AFEPG_DLY_W-1:0] pair_delay [PAIRS];

  // Reset release through two flip-flops
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Access decode
  // phase write detect
  assign wr_phase = i_reg_wr && (i_reg_addr == AFEPG_OFS_PHASE45 ||
                                 i_reg_addr == AFEPG_OFS_PHASE_LO);
  assign rd_status = i_reg_rd && (i_reg_addr == AFEPG_OFS_STATUS);

  // Phase delay registers
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_pair45 <= '0;
      delay_pair23 <= '0;
      delay_pair01 <= '0;
    end else if (i_clk_en && i_reg_wr) begin
      if (i_reg_addr == AFEPG_OFS_PHASE45) begin
        delay_pair45 <= i_reg_wdata[AFEPG_POS_PAIR45 +: AFEPG_DLY_W];
      end
      if (i_reg_addr == AFEPG_OFS_PHASE_LO) begin
        delay_pair23 <= i_reg_wdata[AFEPG_POS_PAIR23 +: AFEPG_DLY_W];
        delay_pair01 <= i_reg_wdata[AFEPG_POS_PAIR01 +: AFEPG_DLY_W];
      end
    end
  end

  // Gain register
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_gain_code <= '0;
    end else if (i_clk_en && i_reg_wr && i_reg_addr == AFEPG_OFS_GAIN) begin
      channel_gain_code <= i_reg_wdata[CHANNELS*3-1:0];
    end
  end

  // Status/communication control fields; reserved bits 13-12 not stored
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '{read_inc: AFEPG_RST_READ, write_inc: AFEPG_RST_WRITE,
               idle_drive: 1'b0, combine: 1'b0, crc32: 1'b0,
               data_width: AFEPG_RST_DATAW, comm_crc: 1'b0, int_en: 1'b0};
    end else if (i_clk_en && i_reg_wr && i_reg_addr == AFEPG_OFS_STATUS) begin
      cfg.read_inc <= i_reg_wdata[AFEPG_POS_READ +: 2];
      cfg.write_inc <= i_reg_wdata[AFEPG_POS_WRITE];
      cfg.idle_drive <= i_reg_wdata[AFEPG_POS_IDLE];
      cfg.combine <= i_reg_wdata[AFEPG_POS_COMBINE];
      cfg.crc32 <= i_reg_wdata[AFEPG_POS_CRCW];
      cfg.data_width <= i_reg_wdata[AFEPG_POS_DATAW +: 2];
      cfg.comm_crc <= i_reg_wdata[AFEPG_POS_COMMCRC];
      cfg.int_en <= i_reg_wdata[AFEPG_POS_INTEN];
    end
  end
  assign o_cfg = cfg;

  // Read data, registered; unmapped addresses return zero
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= '0;
    end else if (i_clk_en && i_reg_rd) begin
      case (i_reg_addr)
        AFEPG_OFS_PHASE45: o_reg_rdata <= {12'h000, delay_pair45};
        AFEPG_OFS_PHASE_LO: o_reg_rdata <= {delay_pair23, delay_pair01};
        AFEPG_OFS_GAIN: o_reg_rdata <= {6'h00, channel_gain_code};
        AFEPG_OFS_STATUS: o_reg_rdata <= {cfg.read_inc, cfg.write_inc,
          cfg.idle_drive, cfg.combine, cfg.crc32, cfg.data_width,
          cfg.comm_crc, cfg.int_en, 8'h00, channel_ready_flags};
        default: o_reg_rdata <= '0;
      endcase
    end
  end

  // Address walk for the serial framer
  // read address walk
  always_comb begin
    o_next_rd_addr = i_reg_addr;
    case (afepg_rd_e'(cfg.read_inc))
      AFEPG_RD_SAME: o_next_rd_addr = i_reg_addr;
      AFEPG_RD_GROUP: o_next_rd_addr = {i_reg_addr[4:1], ~i_reg_addr[0]};
      AFEPG_RD_TYPE: begin
        if (i_reg_addr == AFEPG_TYPE_SPLIT - 5'h01) begin
          o_next_rd_addr = 5'h00;
        end else if (i_reg_addr == AFEPG_MAP_LAST) begin
          o_next_rd_addr = AFEPG_TYPE_SPLIT;
        end else begin
          o_next_rd_addr = i_reg_addr + 5'h01;
        end
      end
      AFEPG_RD_MAP: o_next_rd_addr = i_reg_addr + 5'h01;
      default: o_next_rd_addr = i_reg_addr;
    endcase
  end

  always_comb begin
    if (!cfg.write_inc) begin
      o_next_wr_addr = i_reg_addr;
    end else if (i_reg_addr == AFEPG_MAP_LAST || i_reg_addr < AFEPG_WR_FIRST) begin
      o_next_wr_addr = AFEPG_WR_FIRST;
    end else begin
      o_next_wr_addr = i_reg_addr + 5'h01;
    end
  end

  // gain code to shift, reserved codes unity
  for (genvar c = 0; c < CHANNELS; c++) begin : g_gain
    assign o_gain_shift[3*c +: 3] =
      (channel_gain_code[3*c +: 3] > AFEPG_GAIN_MAX) ? 3'h0 :
      channel_gain_code[3*c +: 3];
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_chan_restart <= '0;
      restart_q <= 1'b0;
      active_q <= '0;
    end else if (i_clk_en) begin
      o_chan_restart <= wr_phase ? i_chan_active : '0;
      restart_q <= wr_phase;
      active_q <= i_chan_active;
    end
  end

  assign pair_delay[0] = delay_pair01;
  assign pair_delay[1] = delay_pair23;
  assign pair_delay[2] = delay_pair45;

  // Start sequencing: reference (odd) starts at once, even waits its delay
  for (genvar p = 0; p < PAIRS; p++) begin : g_pair
    logic [AFEPG_DLY_W-1:0] cnt;
    logic busy;
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt <= '0;
        busy <= 1'b0;
        o_chan_start[2*p] <= 1'b0;
        o_chan_start[2*p+1] <= 1'b0;
      end else if (i_clk_en) begin
        o_chan_start[2*p+1] <= restart_q && active_q[2*p+1];
        o_chan_start[2*p] <= 1'b0;
        if (restart_q) begin
          cnt <= pair_delay[p];
          busy <= (pair_delay[p] != '0);
          o_chan_start[2*p] <= (pair_delay[p] == '0) && active_q[2*p];
        end else if (busy) begin
          cnt <= cnt - 1'b1;
          if (cnt == 1) begin
            busy <= 1'b0;
            o_chan_start[2*p] <= active_q[2*p];
          end
        end
      end
    end
  end

  // Channel ready flags; a new event wins over the read that sets them
  // flags low when ready
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_ready_flags <= AFEPG_RST_FLAGS;
    end else if (i_clk_en) begin
      channel_ready_flags <= (rd_status ? AFEPG_RST_FLAGS :
                              channel_ready_flags) & ~i_chan_ready;
    end
  end

  // Combined mode waits until every active channel has reported
  assign covered = pending | i_chan_ready;
  assign combined_fire = (i_chan_active != '0) &&
                         ((covered & i_chan_active) == i_chan_active);

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= '0;
      dr_pulse <= 1'b0;
      o_chan_latch <= '0;
    end else if (i_clk_en) begin
      if (cfg.combine) begin
        pending <= combined_fire ? '0 : covered;
        dr_pulse <= combined_fire;
        o_chan_latch <= combined_fire ? {CHANNELS{1'b1}} : '0;
      end else begin
        pending <= '0;
        dr_pulse <= |i_chan_ready;
        o_chan_latch <= i_chan_ready;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_hold <= 1'b0;
    end else if (i_clk_en) begin
      if (cfg.int_en && i_map_crc_error) begin
        alarm_hold <= 1'b1;
      end else if (i_lock_key == AFEPG_LOCK_KEY) begin
        alarm_hold <= 1'b0;
      end
    end
  end

  // pin drive, low on pulse or alarm, idle high or floating
  assign o_ready_pin_out = !(dr_pulse || alarm_hold);
  assign o_ready_pin_oe = dr_pulse || alarm_hold || cfg.idle_drive;

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  AST_RESTART: assert property (
    i_clk_en && wr_phase |=> o_chan_restart == $past(i_chan_active))
    else $error("restart mask differs from active channels");

  AST_PAIR45: assert property (
    i_clk_en && i_reg_wr && i_reg_addr == AFEPG_OFS_PHASE45
    |=> delay_pair45 == $past(i_reg_wdata[11:0]))
    else $error("pair45 delay not stored");

  AST_LO_READ: assert property (
    i_clk_en && i_reg_rd && i_reg_addr == AFEPG_OFS_PHASE_LO
    |=> o_reg_rdata == {$past(delay_pair23), $past(delay_pair01)})
    else $error("low phase readback wrong");

  AST_START_GAP: assert property (
    i_clk_en && restart_q && active_q[0] && delay_pair01 == 12'h003
    ##1 (i_clk_en && !restart_q)[*3] |=> o_chan_start[0])
    else $error("pair01 start not after delay");

  AST_GAIN: assert property (
    channel_gain_code[2:0] > AFEPG_GAIN_MAX |-> o_gain_shift[2:0] == 3'h0)
    else $error("reserved gain not unity");

  AST_RD_SAME: assert property (
    cfg.read_inc == 2'h0 |-> o_next_rd_addr == i_reg_addr)
    else $error("read address moved in single mode");

  AST_WR_WRAP: assert property (
    cfg.write_inc && i_reg_addr == AFEPG_MAP_LAST
    |-> o_next_wr_addr == AFEPG_WR_FIRST)
    else $error("write address did not wrap");

  AST_IDLE_FLOAT: assert property (
    !dr_pulse && !alarm_hold && !cfg.idle_drive |-> !o_ready_pin_oe)
    else $error("idle pin driven while float selected");

  AST_SEPARATE: assert property (
    i_clk_en && !cfg.combine && |i_chan_ready
    |=> !o_ready_pin_out && o_ready_pin_oe)
    else $error("missing per-channel pulse");

  AST_ALARM: assert property (
    i_clk_en && cfg.int_en && i_map_crc_error ##1
    i_lock_key != AFEPG_LOCK_KEY |-> !o_ready_pin_out ##1 !o_ready_pin_out)
    else $error("alarm did not hold pin low");

  AST_NO_ALARM: assert property (
    !cfg.int_en && !alarm_hold |=> !$rose(alarm_hold))
    else $error("alarm raised while disabled");

  AST_SET_WINS: assert property (
    i_clk_en && rd_status && i_chan_ready[0]
    |=> !channel_ready_flags[0])
    else $error("ready event lost under status read");

  AST_READ_SETS: assert property (
    i_clk_en && rd_status && i_chan_ready == '0
    |=> channel_ready_flags == AFEPG_RST_FLAGS)
    else $error("status read did not set flags");

  AST_DATA_READ: assert property (
    i_clk_en && i_chan_data_rd && !rd_status
    |=> (channel_ready_flags & ~$past(channel_ready_flags)) == '0)
    else $error("data read changed flags");

  AST_LATCH_ALL: assert property (
    cfg.combine && dr_pulse |-> o_chan_latch == {CHANNELS{1'b1}})
    else $error("combined latch incomplete");

  COV_RESTART: cover property (i_clk_en && wr_phase);
  COV_COMBINED: cover property (cfg.combine && dr_pulse);
  COV_ALARM: cover property ($rose(alarm_hold) ##[1:50] $fell(alarm_hold));
  COV_STATUS_READ: cover property (rd_status && |i_chan_ready);

endmodule : afepg_regs

// ### afepg_host.sv
// Host model that drives the register bus of the bank
`timescale 1ns/1ps
module afepg_host (
  input wire logic i_sys_clk,
  output logic [4:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [23:0] o_wdata
);
  // Bus idle at time zero
  initial begin
    o_addr = 5'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 24'h000000;
  end
  // One word per strobe, then release and an optional idle gap
  task automatic access(input logic wr, input logic [4:0] a,
      input logic [23:0] d, input int gap);
    @(negedge i_sys_clk);
    o_addr = a;
    o_wr = wr;
    o_rd = !wr;
    o_wdata = (a == 5'h0c) ? (d & 24'hffcfff) : d;
    @(negedge i_sys_clk);
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
    repeat (gap) @(negedge i_sys_clk);
  endtask : access
  // Park an address on the idle bus for the address walk outputs
  task automatic put_addr(input logic [4:0] a);
    o_addr = a;
  endtask : put_addr
endmodule : afepg_host

// ### testbench.sv
// Self-checking bench for the phase, gain and status register bank
`timescale 1ns/1ps
module testbench;
  import afepg_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] act = 6'h3f;
  logic [5:0] rdy = 6'h00;
  logic crc_err = 1'b0;
  logic drd = 1'b0;
  logic ce = 1'b1;
  logic [7:0] key = 8'h00;
  logic [4:0] addr, nra, nwa;
  logic wr, rd, rd_take;
  logic [23:0] wdata, rdata, w;
  afepg_cfg_s cfg;
  logic [17:0] gsh;
  logic [5:0] rst_o, start, latch;
  logic pin, oe;
  logic [23:0] exp_q[$];
  int n_mismatch = 0;
  int check_count = 0;
  logic [5:0] seq [5] = '{6'h3b, 6'h3a, 6'h00, 6'h00, 6'h01};
  logic [11:0] tbl [8] = '{12'hfe0, 12'hca6, 12'h8e0, 12'hbe8,
      12'h98d, 12'h5ac, 12'h58d, 12'h18c};

  // Clock at 100 ns period
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  afepg_host host (.i_sys_clk(sys_clk), .o_addr(addr), .o_wr(wr),
      .o_rd(rd), .o_wdata(wdata));

  afepg_regs dut (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
      .i_clk_en(ce), .i_reg_addr(addr), .i_reg_wr(wr),
      .i_reg_wdata(wdata), .i_reg_rd(rd), .i_chan_data_rd(drd),
      .i_chan_active(act), .i_chan_ready(rdy), .i_map_crc_error(crc_err),
      .i_lock_key(key), .o_reg_rdata(rdata), .o_next_rd_addr(nra),
      .o_next_wr_addr(nwa), .o_cfg(cfg), .o_gain_shift(gsh),
      .o_chan_restart(rst_o), .o_chan_start(start), .o_chan_latch(latch),
      .o_ready_pin_out(pin), .o_ready_pin_oe(oe));

  // Compare one value and count it
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Note the expected word, then issue the read
  task automatic rd_exp(input logic [4:0] a, input logic [23:0] e);
    exp_q.push_back(e);
    host.access(1'b0, a, 24'h000000, 0);
  endtask : rd_exp

  // Wait one cycle, to the next falling clock edge
  task automatic tick;
    @(negedge sys_clk);
  endtask : tick

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  // Read data watcher takes the oldest note after each read edge
  always @(posedge sys_clk) rd_take <= rd;
  always @(negedge sys_clk) begin
    if (rd_take === 1'b1) chk(rdata, exp_q.pop_front());
  end

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    close_out();
  end

  // Main sequence
  initial begin
    void'($urandom(47959));
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk({pin, oe}, 24'h2);
    rd_exp(AFEPG_OFS_STATUS, 24'ha1003f);
    for (int a = 9; a < 12; a++) rd_exp(5'(a), 24'h0);
    rd_exp(5'h1e, 24'h0);
    $display("reset values done");
    repeat (4) begin
      w = 24'($urandom());
      host.access(1'b1, AFEPG_OFS_PHASE45, w, $urandom_range(2));
      rd_exp(AFEPG_OFS_PHASE45, w & 24'h000fff);
      host.access(1'b1, AFEPG_OFS_PHASE_LO, w, $urandom_range(2));
      rd_exp(AFEPG_OFS_PHASE_LO, w);
      host.access(1'b1, AFEPG_OFS_GAIN, w, $urandom_range(2));
      rd_exp(AFEPG_OFS_GAIN, w & 24'h03ffff);
      host.access(1'b1, 5'h1e, w, 0);
      rd_exp(5'h1e, 24'h0);
    end
    host.access(1'b1, AFEPG_OFS_GAIN, 24'h03eb1a, 0);
    chk(24'(gsh), 24'h000b1a);
    host.access(1'b1, AFEPG_OFS_GAIN, 24'hfc0008, 0);
    chk(24'(gsh), 24'h000008);
    // Clock enable low freezes the gain register
    ce = 1'b0;
    host.access(1'b1, AFEPG_OFS_GAIN, 24'h000001, 0);
    ce = 1'b1;
    chk(24'(gsh), 24'h000008);
    $display("phase and gain done");
    for (int i = 0; i < 4; i++) begin
      w = {2'(i), 4'($urandom()), 2'(i), 2'($urandom()), 2'b00,
          6'($urandom()), 6'($urandom())};
      host.access(1'b1, AFEPG_OFS_STATUS, w, 0);
      rd_exp(AFEPG_OFS_STATUS, (w & 24'hffc000) | 24'h3f);
      chk(24'(cfg), 24'(w[23:14]));
    end
    $display("status fields done");
    act = 6'h3b;
    host.access(1'b1, AFEPG_OFS_PHASE45, 24'h0, 0);
    host.access(1'b1, AFEPG_OFS_PHASE_LO, 24'h000003, 0);
    for (int k = 0; k < 5; k++) begin
      chk(24'(k == 0 ? rst_o : start), 24'(seq[k]));
      tick();
    end
    $display("restart done");
    act = 6'h3f;
    host.access(1'b1, AFEPG_OFS_STATUS, 24'hb10000, 1);
    rdy = 6'h01;
    tick();
    rdy = 6'h00;
    chk({pin, oe, latch}, 24'h41);
    tick();
    chk({pin, oe}, 24'h3);
    drd = 1'b1;
    tick();
    drd = 1'b0;
    rd_exp(AFEPG_OFS_STATUS, 24'hb1003e);
    rd_exp(AFEPG_OFS_STATUS, 24'hb1003f);
    // Ready event in the same cycle as a status read keeps its flag low
    exp_q.push_back(24'hb1003f);
    fork
      host.access(1'b0, AFEPG_OFS_STATUS, 24'h000000, 0);
      begin
        tick();
        rdy = 6'h01;
        tick();
        rdy = 6'h00;
      end
    join
    rd_exp(AFEPG_OFS_STATUS, 24'hb1003e);
    act = 6'h3b;
    host.access(1'b1, AFEPG_OFS_STATUS, 24'hb90000, 1);
    rdy = 6'h03;
    tick();
    rdy = 6'h38;
    chk(24'(pin), 24'h1);
    tick();
    rdy = 6'h00;
    chk({pin, latch & act}, 24'h3b);
    $display("data ready done");
    host.access(1'b1, AFEPG_OFS_STATUS, 24'hb14000, 0);
    crc_err = 1'b1;
    tick();
    crc_err = 1'b0;
    repeat (5) begin
      tick();
      chk(24'(pin), 24'h0);
    end
    key = AFEPG_LOCK_KEY;
    repeat (3) tick();
    chk(24'(pin), 24'h1);
    key = 8'h00;
    host.access(1'b1, AFEPG_OFS_STATUS, 24'hb10000, 0);
    crc_err = 1'b1;
    tick();
    crc_err = 1'b0;
    repeat (4) begin
      tick();
      chk(24'(pin), 24'h1);
    end
    $display("alarm done");
    foreach (tbl[i]) begin
      host.access(1'b1, AFEPG_OFS_STATUS, {tbl[i][11:10], 22'h210000}, 0);
      host.put_addr(tbl[i][9:5]);
      #1 chk(24'(nra), 24'(tbl[i][4:0]));
    end
    host.put_addr(5'h1f);
    #1 chk(24'(nwa), 24'h09);
    host.access(1'b1, AFEPG_OFS_STATUS, 24'h810000, 0);
    host.put_addr(5'h0c);
    #1 chk(24'(nwa), 24'h0c);
    repeat (2) tick();
    chk(24'(oe), 24'h0);
    $display("address walk done");
    close_out();
  end
endmodule : testbench
